//--- common/ppg_defines.vh
// Constants shared by the seconds-pulse timing generator.
`ifndef PPG_DEFINES_VH
`define PPG_DEFINES_VH
`define PPG_CLK_HZ 10000000
`define PPG_REF_HZ 20000000
`define PPG_SEC_DIV 10000000
`define PPG_PULSE_US 20
`define PPG_PULSE_CYC ((`PPG_PULSE_US * (`PPG_CLK_HZ / 1000000)))
`define PPG_MHZ_DIV 10
`define PPG_KHZ_DIV 10
`define PPG_SCAN_DIV 10000
`define PPG_DIGITS 3
`define PPG_FAST_STEP 8'h01
`endif

//--- rtl/ppg_timing_generator.v
// Seconds-pulse timing generator with dividers, offset pulse and wall clock.
`timescale 1ns/1ps
// Function
// - Divide by ten million, 20 us pulse.
// - Make 1 MHz and 100 kHz clocks.
// - First reference edge clears and holds the seconds divider; the 1 MHz and 100 kHz stages keep running.
// - Second reference edge releases the seconds divider.
// - Two identical seconds pulse copies.
// - Wall clock counts seconds, 24-hour format.
// - Fast and start set inputs; the slow input only steps on alternate seconds wraps, which already step the clock.
// - Display scanned one digit group at once.
// - Offset pulse from a compare on the seconds counter.
// - Delay finishes interval later by count.
// - Advance finishes interval earlier by count.
`include "ppg_defines.vh"
module ppg_timing_generator
#(
    parameter SEC_DIV = `PPG_SEC_DIV,
    parameter SCAN_DIV = `PPG_SCAN_DIV
)
(
    input wire ref_clk_i,
    input wire srst_i,
    input wire tick_en_i,
    input wire ext_ref_i,
    input wire [23:0] offset_count_i,
    input wire advance_sel_i,
    input wire set_fast_i,
    input wire set_slow_i,
    input wire set_start_i,
    output reg pps_a_o,
    output reg pps_b_o,
    output reg pps_offset_o,
    output reg clk_1mhz_o,
    output reg clk_100khz_o,
    output reg sync_hold_o,
    output reg [7:0] digit_bcd_o,
    output reg [2:0] digit_sel_o,
    output reg [4:0] hours_o,
    output reg [5:0] minutes_o,
    output reg [5:0] seconds_o
);
    // The 10 MHz timebase is a one-cycle enable (tick_en_i) on ref_clk_i.
    // Full-width copies are cut to counter width on purpose.
    localparam [31:0] SEC_DIV_FULL = SEC_DIV;
    localparam [31:0] SEC_LAST_FULL = SEC_DIV - 1;
    localparam [31:0] PULSE_FULL = `PPG_PULSE_CYC;
    localparam [31:0] SCAN_LAST_FULL = SCAN_DIV - 1;
    localparam [23:0] SEC_DIV_W = SEC_DIV_FULL[23:0];
    localparam [23:0] SEC_LAST = SEC_LAST_FULL[23:0];
    localparam [23:0] PULSE_LEN = PULSE_FULL[23:0];
    localparam [13:0] SCAN_LAST = SCAN_LAST_FULL[13:0];
    reg ref_s1_ff;
    reg ref_s2_ff;
    reg ref_s3_ff;
    reg ref_prev_ff;
    reg [1:0] sync_st_ff;
    reg [23:0] sec_cnt_ff;
    reg [23:0] off_cnt_ff;
    reg [23:0] pulse_cnt_ff;
    reg [23:0] opulse_cnt_ff;
    reg [3:0] div1_ff;
    reg [3:0] div2_ff;
    reg [4:0] hr_ff;
    reg [5:0] mn_ff;
    reg [5:0] sc_ff;
    reg running_ff;
    reg [13:0] scan_cnt_ff;
    reg [1:0] scan_idx_ff;
    reg fast_s1_ff, fast_s2_ff, fast_s3_ff;
    reg slow_s1_ff, slow_s2_ff, slow_s3_ff;
    reg start_s1_ff, start_s2_ff, start_s3_ff;
    reg slow_tog_ff;
    wire ref_lvl;
    wire ref_rise;
    wire sec_wrap;
    wire [23:0] off_target;
    wire off_hit;
    wire advance_tod;
    reg [7:0] nxt_bcd;
    wire [23:0] off_mod;
    wire [4:0] hr_tens;
    wire [4:0] hr_ones;
    wire [5:0] mn_tens;
    wire [5:0] mn_ones;
    wire [5:0] sc_tens;
    wire [5:0] sc_ones;

    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;

    assign ref_lvl = (ref_s2_ff == ref_s3_ff) ? ref_s3_ff : ref_prev_ff;
    assign ref_rise = ref_lvl & ~ref_prev_ff;
    assign sec_wrap = tick_en_i && (sec_cnt_ff == SEC_LAST);
    // zero offset lands on the master wrap; each count is one tick.
    // delay ends later by the count; advance ends earlier.
    // A count of a whole second or more folds back into one second.
    // A fold that lands on zero must still coincide with the master wrap.
    assign off_mod = offset_count_i % SEC_DIV_W;
    assign off_target = (off_mod == 24'h000000) ? SEC_LAST :
        advance_sel_i ? (SEC_LAST - off_mod) :
        (off_mod - 24'h000001);
    assign off_hit = tick_en_i && (sec_cnt_ff == off_target) && (sync_st_ff == ST_RUN);
    assign advance_tod = (sec_wrap && running_ff) || (fast_s3_ff && tick_en_i && sec_cnt_ff[17:0] == 18'h00000)
        || (slow_s3_ff && sec_wrap && slow_tog_ff);

    always @(posedge ref_clk_i)
    begin
        ref_s1_ff <= ext_ref_i;
        ref_s2_ff <= ref_s1_ff;
        ref_s3_ff <= ref_s2_ff;
        fast_s1_ff <= set_fast_i;
        fast_s2_ff <= fast_s1_ff;
        fast_s3_ff <= fast_s2_ff;
        slow_s1_ff <= set_slow_i;
        slow_s2_ff <= slow_s1_ff;
        slow_s3_ff <= slow_s2_ff;
        start_s1_ff <= set_start_i;
        start_s2_ff <= start_s1_ff;
        start_s3_ff <= start_s2_ff;
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            ref_prev_ff <= 1'b0;
            sync_st_ff <= ST_RUN;
            sec_cnt_ff <= 24'h000000;
            sync_hold_o <= 1'b0;
        end
        else
        begin
            ref_prev_ff <= ref_lvl;
            case (sync_st_ff)
                ST_RUN:
                begin
                    // first reference edge clears and holds.
                    if (ref_rise)
                    begin
                        sync_st_ff <= ST_HOLD;
                        sec_cnt_ff <= 24'h000000;
                        sync_hold_o <= 1'b1;
                    end
                    // divide the timebase by ten million.
                    else if (tick_en_i)
                        sec_cnt_ff <= sec_wrap ? 24'h000000 : sec_cnt_ff + 24'h000001;
                end
                ST_HOLD:
                begin
                    sec_cnt_ff <= 24'h000000;
                    // second edge releases; needs a distinct edge.
                    if (ref_rise)
                    begin
                        sync_st_ff <= ST_RUN;
                        sync_hold_o <= 1'b0;
                    end
                end
                default:
                    sync_st_ff <= ST_RUN;
            endcase
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            pulse_cnt_ff <= 24'h000000;
            opulse_cnt_ff <= 24'h000000;
            pps_a_o <= 1'b0;
            pps_b_o <= 1'b0;
            pps_offset_o <= 1'b0;
            off_cnt_ff <= 24'h000000;
        end
        else
        begin
            // master pulse lasts 20 us of timebase ticks.
            if (sec_wrap && sync_st_ff == ST_RUN)
                pulse_cnt_ff <= PULSE_LEN;
            else if (tick_en_i && pulse_cnt_ff != 24'h000000)
                pulse_cnt_ff <= pulse_cnt_ff - 24'h000001;
            pps_a_o <= (pulse_cnt_ff != 24'h000000);
            pps_b_o <= (pulse_cnt_ff != 24'h000000);
            // cascaded offset counter records the offset interval.
            if (tick_en_i)
                off_cnt_ff <= off_hit ? 24'h000000 : off_cnt_ff + 24'h000001;
            if (off_hit)
                opulse_cnt_ff <= PULSE_LEN;
            else if (tick_en_i && opulse_cnt_ff != 24'h000000)
                opulse_cnt_ff <= opulse_cnt_ff - 24'h000001;
            pps_offset_o <= (opulse_cnt_ff != 24'h000000);
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            div1_ff <= 4'h0;
            div2_ff <= 4'h0;
            clk_1mhz_o <= 1'b0;
            clk_100khz_o <= 1'b0;
        end
        // decade stages give 1 MHz and 100 kHz.
        else if (tick_en_i)
        begin
            div1_ff <= (div1_ff == 4'h9) ? 4'h0 : div1_ff + 4'h1;
            clk_1mhz_o <= (div1_ff < 4'h5);
            if (div1_ff == 4'h9)
            begin
                div2_ff <= (div2_ff == 4'h9) ? 4'h0 : div2_ff + 4'h1;
                clk_100khz_o <= (div2_ff < 4'h5);
            end
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            hr_ff <= 5'h00;
            mn_ff <= 6'h00;
            sc_ff <= 6'h00;
            running_ff <= 1'b1;
            slow_tog_ff <= 1'b0;
            // Time outputs are cleared so that nothing unknown leaves reset.
            hours_o <= 5'h00;
            minutes_o <= 6'h00;
            seconds_o <= 6'h00;
        end
        else
        begin
            // start pauses the clock at zero seconds until released.
            if (start_s3_ff)
            begin
                running_ff <= 1'b0;
                sc_ff <= 6'h00;
            end
            else
                running_ff <= 1'b1;
            if (sec_wrap)
                slow_tog_ff <= ~slow_tog_ff;
            if (advance_tod && !start_s3_ff)
            begin
                if (sc_ff == 6'd59)
                begin
                    sc_ff <= 6'h00;
                    if (mn_ff == 6'd59)
                    begin
                        mn_ff <= 6'h00;
                        hr_ff <= (hr_ff == 5'd23) ? 5'h00 : hr_ff + 5'h01;
                    end
                    else
                        mn_ff <= mn_ff + 6'h01;
                end
                else
                    sc_ff <= sc_ff + 6'h01;
            end
            hours_o <= hr_ff;
            minutes_o <= mn_ff;
            seconds_o <= sc_ff;
        end
    end

    // Binary to BCD split; every field is below 60, so each digit fits 4 bits.
    assign hr_tens = hr_ff / 5'd10;
    assign hr_ones = hr_ff % 5'd10;
    assign mn_tens = mn_ff / 6'd10;
    assign mn_ones = mn_ff % 6'd10;
    assign sc_tens = sc_ff / 6'd10;
    assign sc_ones = sc_ff % 6'd10;

    always @*
    begin
        case (scan_idx_ff)
            2'd0: nxt_bcd = {hr_tens[3:0], hr_ones[3:0]};
            2'd1: nxt_bcd = {mn_tens[3:0], mn_ones[3:0]};
            default: nxt_bcd = {sc_tens[3:0], sc_ones[3:0]};
        endcase
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            scan_cnt_ff <= 14'h0000;
            scan_idx_ff <= 2'd0;
            digit_sel_o <= 3'h0;
            digit_bcd_o <= 8'h00;
        end
        else
        begin
            // one digit group enabled at a time.
            if (scan_cnt_ff == SCAN_LAST)
            begin
                scan_cnt_ff <= 14'h0000;
                scan_idx_ff <= (scan_idx_ff == 2'd2) ? 2'd0 : scan_idx_ff + 2'd1;
            end
            else
                scan_cnt_ff <= scan_cnt_ff + 14'h0001;
            digit_sel_o <= 3'h1 << scan_idx_ff;
            digit_bcd_o <= nxt_bcd;
        end
    end
endmodule

//--- testbench/ppg_checker_assertions.sv
// Concurrent checks on the timing generator ports.
`timescale 1ns/1ps
module ppg_checker #(parameter SEC_DIV = 1000, parameter SCAN_DIV = 4) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic sync_hold_o,
    input wire logic pps_a_o,
    input wire logic pps_b_o,
    input wire logic clk_1mhz_o,
    input wire logic clk_100khz_o,
    input wire logic [2:0] digit_sel_o,
    input wire logic [4:0] hours_o,
    input wire logic [5:0] minutes_o,
    input wire logic [5:0] seconds_o
);
    reg [15:0] hi_ff = 16'h0;
    reg [15:0] per_ff = 16'h0;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Period count is zero, hence invalid, until a pulse follows reset or a hold.
    always @(posedge ref_clk_i)
    begin
        hi_ff <= (pps_a_o && !srst_i) ? hi_ff + 16'h1 : 16'h0;
        if (srst_i || sync_hold_o)
            per_ff <= 16'h0;
        else if (pps_a_o && hi_ff == 16'h0)
            per_ff <= 16'h1;
        else if (per_ff != 16'h0)
            per_ff <= per_ff + 16'h1;
    end
    a_copies_match: assert property (pps_a_o == pps_b_o) else $error("copy");
    a_pulse_width: assert property ($fell(pps_a_o) && !sync_hold_o |-> hi_ff == 16'd400) else $error("width");
    a_pps_period: assert property ($rose(pps_a_o) && per_ff != 16'h0 |-> per_ff == 2 * SEC_DIV) else $error("period");
    a_hold_quiet: assert property (sync_hold_o && $past(sync_hold_o) |-> !$rose(pps_a_o)) else $error("held");
    a_mhz_half: assert property (disable iff (srst_i || sync_hold_o)
        $changed(clk_1mhz_o) |=> $stable(clk_1mhz_o)[*8]) else $error("mhz");
    a_khz_half: assert property (disable iff (srst_i || sync_hold_o)
        $changed(clk_100khz_o) |=> $stable(clk_100khz_o)[*8]) else $error("khz");
    a_scan_onehot: assert property (digit_sel_o != 3'h0 |-> $onehot(digit_sel_o)) else $error("scan");
    a_time_range: assert property (hours_o < 5'd24 && minutes_o < 6'd60 && seconds_o < 6'd60) else $error("time");
    c_pulse: cover property ($rose(pps_a_o));
    c_hold: cover property ($rose(sync_hold_o));
    c_release: cover property ($fell(sync_hold_o));
endmodule
bind ppg_timing_generator ppg_checker #(.SEC_DIV(SEC_DIV), .SCAN_DIV(SCAN_DIV)) ppg_checker_i (.ref_clk_i, .srst_i,
    .sync_hold_o, .pps_a_o, .pps_b_o, .clk_1mhz_o, .clk_100khz_o, .digit_sel_o, .hours_o, .minutes_o, .seconds_o);

//--- testbench/ppg_ref_source.sv
// Model of the external reference pulse source.
`timescale 1ns/1ps
module ppg_ref_source (
    input wire logic ref_clk_i,
    output logic ext_ref_o
);
    initial ext_ref_o = 1'h0;
    task automatic ref_pulse(input int hi_cyc);
        @(negedge ref_clk_i);
        ext_ref_o = 1'h1;
        repeat (hi_cyc) @(negedge ref_clk_i);
        ext_ref_o = 1'h0;
    endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the timing generator.
`timescale 1ns/1ps
module testbench;
    localparam int SD = 1000;
    logic ref_clk_i = 1'h0, srst_i = 1'h1, tick_en_i = 1'h0, advance_sel_i = 1'h0, set_start_i = 1'h0;
    logic set_fast_i = 1'h0, set_slow_i = 1'h0, pa_q, po_q, m_q, k_q;
    logic [23:0] offset_count_i = 24'h0;
    logic [31:0] rng = 32'h7488, s0, t_e;
    logic [2:0] sel_or = 3'h0;
    wire ext_ref_i, pps_a_o, pps_b_o, pps_offset_o, clk_1mhz_o, clk_100khz_o, sync_hold_o;
    wire [7:0] digit_bcd_o;
    wire [2:0] digit_sel_o;
    wire [4:0] hours_o;
    wire [5:0] minutes_o, seconds_o;
    int error_cnt = 0, checks = 0, cyc = 0, t_a, t_o, n_a = 0, n_o = 0, n_m = 0, n_k = 0, m_cnt, k_cnt;
    always #25 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) tick_en_i <= ~tick_en_i;
    ppg_ref_source ppg_ref_source_i (.ref_clk_i, .ext_ref_o(ext_ref_i));
    ppg_timing_generator #(.SEC_DIV(SD), .SCAN_DIV(4)) ppg_timing_generator_i (.*);
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [7:0] exp_bcd(input logic [2:0] sel);
        int v;
        v = sel[0] ? hours_o : (sel[1] ? minutes_o : seconds_o);
        return {4'(v / 10), 4'(v % 10)};
    endfunction
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input bit off);
        int n0;
        n0 = off ? n_o : n_a;
        while ((off ? n_o : n_a) == n0) @(negedge ref_clk_i);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic ofs(input int d, input logic adv);
        offset_count_i = 24'(d);
        advance_sel_i = adv;
        wt(0);
        wt(0);
        wt(adv | (d != 0));
        if (adv)
        begin
            wt(0);
            cmp(t_a - t_o, 2 * d);
        end
        else
            cmp(t_o - t_a, 2 * d);
        $display("offset d=%0d adv=%0b done", d, adv);
    endtask
    // Rise times and divider edge counts per master second.
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        {pa_q, po_q, m_q, k_q} <= {pps_a_o, pps_offset_o, clk_1mhz_o, clk_100khz_o};
        n_m <= (pps_a_o && !pa_q ? 0 : n_m) + int'(clk_1mhz_o && !m_q);
        n_k <= (pps_a_o && !pa_q ? 0 : n_k) + int'(clk_100khz_o && !k_q);
        if (pps_a_o && !pa_q)
        begin
            {t_a, n_a, m_cnt, k_cnt} <= {cyc, n_a + 1, n_m, n_k};
        end
        if (pps_offset_o && !po_q)
        begin
            {t_o, n_o} <= {cyc, n_o + 1};
        end
        if (cyc == 90000)
        begin
            error_cnt++;
            close_out();
        end
    end
    initial
    begin
        idle(8);
        srst_i = 1'h0;
        ofs(0, 0);
        ofs(1, 0);
        ofs(SD - 1, 0);
        ofs(1 + xs() % 300, 0);
        ofs(1 + xs() % 300, 1);
        ofs(1, 1);
        cmp(m_cnt, SD / 10);
        cmp(k_cnt, SD / 100);
        idle(20);
        s0 = seconds_o;
        wt(0);
        idle(20);
        cmp(seconds_o, (s0 + 1) % 60);
        set_start_i = 1'h1;
        wt(0);
        idle(20);
        cmp(seconds_o, 0);
        set_start_i = 1'h0;
        repeat (48)
        begin
            idle(1);
            sel_or |= digit_sel_o;
            cmp(digit_bcd_o, exp_bcd(digit_sel_o));
        end
        cmp(sel_or, 3'h7);
        $display("clock and scan done");
        ppg_ref_source_i.ref_pulse(4);
        idle(8);
        cmp(sync_hold_o, 1);
        s0 = n_a;
        idle(2500);
        cmp(n_a, s0);
        t_e = cyc;
        ppg_ref_source_i.ref_pulse(4);
        idle(8);
        cmp(sync_hold_o, 0);
        wt(0);
        cmp(t_a - t_e - 2 * SD <= 12, 1);
        $display("resync done");
        close_out();
    end
endmodule
